// file: hw/sfl_pkg.sv
// Constants shared by the sensor fault and indicator LED block
package sfl_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EXC_CUR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RREF = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TREF = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COEF1 = 8'h1C; // Orders 1..6 follow
  localparam int NUM_COEF = 6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SW_EN_BIT = 0;
  localparam int EV_SHORT_BIT = 0;
  localparam int EV_OPEN_BIT = 1;
  localparam int EV_OVERCUR_BIT = 2;
  localparam int EV_OVERTEMP_BIT = 3;
  localparam int NUM_EV = 4;
  localparam int ST_ENABLED_BIT = 4;
  localparam int ST_ERRCODE_LSB = 8;
  localparam int ST_STATCODE_LSB = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_SW_EN_RST = 1'b1;
  localparam logic [NUM_EV-1:0] IRQ_MASK_RST = 4'h0;
  localparam int EXC_W = 13;
  localparam logic [EXC_W-1:0] EXC_CUR_RST_UA = 13'h03E8; // 1000 uA
  localparam logic [EXC_W-1:0] EXC_CUR_MIN_UA = 13'h0064; // 100 uA
  localparam logic [EXC_W-1:0] EXC_CUR_MAX_UA = 13'h0FA0; // 4000 uA
  // Reference resistance in milliohm: 1000 ohm platinum
  localparam logic [31:0] RREF_RST_MOHM = 32'h000F_4240;
  // Reference temperature in 0.01 degC
  localparam logic [31:0] TREF_RST = 32'h0000_0000;
  // Coefficients scaled by 1e11: 3.9083e-3 and -5.775e-7
  localparam logic [31:0] COEF1_RST = 32'h174B_AD30;
  localparam logic [31:0] COEF2_RST = 32'hFFFF_1E5A;
  localparam logic [31:0] COEF_HI_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Sensor voltage limits (mV) and temperature band (0.01 degC)
  // ----------------------------------------------------------------
  localparam int SENS_W = 12;
  localparam logic [SENS_W-1:0] SENS_MIN_MV = 12'h050; // 0.08 V
  localparam logic [SENS_W-1:0] SENS_MAX_MV = 12'h8FC; // 2.30 V
  localparam int TEMP_W = 16;
  localparam logic [TEMP_W:0] TEMP_BAND = 17'h00064; // 1 degC

  // ----------------------------------------------------------------
  // Indicator codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_STEADY = 3'h4;
  localparam int CLK_KHZ = 125000;
  localparam int FLASH_ON_MS = 200;
  localparam int FLASH_GAP_MS = 300;
  localparam int GROUP_PAUSE_MS = 1500;
  localparam int FLASH_ON_CYC = FLASH_ON_MS * CLK_KHZ;
  localparam int FLASH_GAP_CYC = FLASH_GAP_MS * CLK_KHZ;
  localparam int GROUP_PAUSE_CYC = GROUP_PAUSE_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    SFL_IDLE,
    SFL_ON,
    SFL_GAP,
    SFL_PAUSE
  } sfl_flash_e;

endpackage

// file: hw/sfl_flasher.sv
// Flash-count pattern generator for one indicator LED
`timescale 1ns/1ps
`default_nettype none
module sfl_flasher #(
  parameter int ON_CYC = sfl_pkg::FLASH_ON_CYC,
  parameter int GAP_CYC = sfl_pkg::FLASH_GAP_CYC,
  parameter int PAUSE_CYC = sfl_pkg::GROUP_PAUSE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] code,
  output logic led
);
  import sfl_pkg::*;

  sfl_flash_e state_reg;
  logic [31:0] cnt_reg;
  logic [2:0] left_reg;
  logic [2:0] code_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A code change restarts the group so a new pattern is never mixed
  // with the tail of the old one
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SFL_IDLE;
      cnt_reg <= 32'h0000_0000;
      left_reg <= 3'h0;
      code_reg <= 3'h0;
    end else begin
      code_reg <= code;
      if (code != code_reg || code == LED_OFF || code == LED_STEADY) begin
        state_reg <= SFL_IDLE;
        cnt_reg <= 32'h0000_0000;
        left_reg <= 3'h0;
      end else begin
        unique case (state_reg)
          SFL_IDLE: begin
            state_reg <= SFL_ON;
            cnt_reg <= 32'(ON_CYC - 1);
            left_reg <= code - 3'h1;
          end
          SFL_ON: begin
            if (cnt_reg != 32'h0000_0000) begin
              cnt_reg <= cnt_reg - 32'h0000_0001;
            end else if (left_reg != 3'h0) begin
              state_reg <= SFL_GAP;
              cnt_reg <= 32'(GAP_CYC - 1);
            end else begin
              state_reg <= SFL_PAUSE;
              cnt_reg <= 32'(PAUSE_CYC - 1);
            end
          end
          SFL_GAP: begin
            if (cnt_reg != 32'h0000_0000) begin
              cnt_reg <= cnt_reg - 32'h0000_0001;
            end else begin
              state_reg <= SFL_ON;
              cnt_reg <= 32'(ON_CYC - 1);
              left_reg <= left_reg - 3'h1;
            end
          end
          SFL_PAUSE: begin
            if (cnt_reg != 32'h0000_0000) begin
              cnt_reg <= cnt_reg - 32'h0000_0001;
            end else begin
              state_reg <= SFL_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Registered LED drive
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      led <= 1'b0;
    end else begin
      led <= (code == LED_STEADY) ||
             (code == code_reg && code != LED_OFF && state_reg == SFL_ON);
    end
  end

endmodule
`default_nettype wire

// file: hw/sfl_top.sv
// Sensor supervision, fault and status LED indication, sensor settings
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sfl_top #(
  parameter int ON_CYC = sfl_pkg::FLASH_ON_CYC,
  parameter int GAP_CYC = sfl_pkg::FLASH_GAP_CYC,
  parameter int PAUSE_CYC = sfl_pkg::GROUP_PAUSE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [sfl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sfl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sfl_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  // Sensor and control loop, same clock
  input wire logic [sfl_pkg::SENS_W-1:0] sens_mv,
  input wire logic sens_valid,
  input wire logic signed [sfl_pkg::TEMP_W-1:0] temp_meas,
  input wire logic signed [sfl_pkg::TEMP_W-1:0] temp_setpoint,
  // Asynchronous pins
  input wire logic hw_enable,
  input wire logic overcur_pin,
  input wire logic overtemp_pin,
  // Indicators and settings
  output logic err_led,
  output logic stat_led,
  output logic [sfl_pkg::EXC_W-1:0] exc_cur_ua,
  output logic [31:0] cfg_rref,
  output logic [31:0] cfg_tref,
  output logic [sfl_pkg::NUM_COEF*32-1:0] cfg_coef
);
  import sfl_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Excitation current is limited to its adjustable range
  function automatic logic [EXC_W-1:0] clamp_cur(input logic [31:0] v);
    logic [EXC_W-1:0] r;
    r = EXC_W'(v);
    if (v > 32'(EXC_CUR_MAX_UA)) begin
      r = EXC_CUR_MAX_UA;
    end else if (v < 32'(EXC_CUR_MIN_UA)) begin
      r = EXC_CUR_MIN_UA;
    end
    return r;
  endfunction

  function automatic logic is_wr(input logic wr,
                                 input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
    return wr && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] en_sync_reg;
  logic [2:0] oc_sync_reg;
  logic [2:0] ot_sync_reg;
  logic en_pin;
  logic oc_lvl;
  logic ot_lvl;
  logic sw_en_reg;
  logic enabled;
  logic short_reg;
  logic open_reg;
  logic short_next;
  logic open_next;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] irq_stat_reg;
  logic [NUM_EV-1:0] irq_mask_reg;
  logic [NUM_EV-1:0] w1c;
  logic [EXC_W-1:0] exc_reg;
  logic [31:0] rref_reg;
  logic [31:0] tref_reg;
  logic [31:0] coef_reg [NUM_COEF];
  logic signed [TEMP_W:0] temp_diff;
  logic [2:0] err_code;
  logic [2:0] stat_code;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops before use; on the two fault pins a third holds the previous level for edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_sync_reg <= 2'h0;
      oc_sync_reg <= 3'h0;
      ot_sync_reg <= 3'h0;
    end else begin
      en_sync_reg <= {en_sync_reg[0], hw_enable};
      oc_sync_reg <= {oc_sync_reg[1:0], overcur_pin};
      ot_sync_reg <= {ot_sync_reg[1:0], overtemp_pin};
    end
  end

  assign en_pin = en_sync_reg[1];
  assign oc_lvl = oc_sync_reg[1];
  assign ot_lvl = ot_sync_reg[1];

  // Both the pin and the software bit must be active; the pin stays a
  // safety gate even when software runs the controller
  assign enabled = en_pin && sw_en_reg;

  // ----------------------------------------------------------------
  // Sensor voltage supervision
  // ----------------------------------------------------------------
  always_comb begin
    short_next = short_reg;
    open_next = open_reg;
    if (sens_valid) begin
      short_next = sens_mv < SENS_MIN_MV;
      open_next = sens_mv > SENS_MAX_MV;
    end
  end

  // Fault levels follow the latest sample, so a repaired sensor clears
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      short_reg <= 1'b0;
      open_reg <= 1'b0;
    end else begin
      short_reg <= short_next;
      open_reg <= open_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign ev[EV_SHORT_BIT] = short_next && !short_reg;
  assign ev[EV_OPEN_BIT] = open_next && !open_reg;
  assign ev[EV_OVERCUR_BIT] = oc_lvl && !oc_sync_reg[2];
  assign ev[EV_OVERTEMP_BIT] = ot_lvl && !ot_sync_reg[2];
  assign w1c = is_wr(reg_wr, reg_addr, OFS_IRQ_STAT) ?
               reg_wdata[NUM_EV-1:0] : 4'h0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~w1c) | ev) & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Control and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sw_en_reg <= CTRL_SW_EN_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else begin
      if (is_wr(reg_wr, reg_addr, OFS_CTRL)) begin
        sw_en_reg <= reg_wdata[CTRL_SW_EN_BIT];
      end
      if (is_wr(reg_wr, reg_addr, OFS_IRQ_MASK)) begin
        irq_mask_reg <= reg_wdata[NUM_EV-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sensor settings
  // ----------------------------------------------------------------
  // clamped current, 1 mA default
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      exc_reg <= EXC_CUR_RST_UA;
    end else if (is_wr(reg_wr, reg_addr, OFS_EXC_CUR)) begin
      exc_reg <= clamp_cur(reg_wdata);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rref_reg <= RREF_RST_MOHM;
      tref_reg <= TREF_RST;
    end else begin
      if (is_wr(reg_wr, reg_addr, OFS_RREF)) begin
        rref_reg <= reg_wdata;
      end
      if (is_wr(reg_wr, reg_addr, OFS_TREF)) begin
        tref_reg <= reg_wdata;
      end
    end
  end

  // Coefficients are stored as given; shape
  // are left to the configuring software, no hardware guards them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      coef_reg[0] <= COEF1_RST;
      coef_reg[1] <= COEF2_RST;
      for (int i = 2; i < NUM_COEF; i++) begin
        coef_reg[i] <= COEF_HI_RST;
      end
    end else begin
      for (int i = 0; i < NUM_COEF; i++) begin
        if (is_wr(reg_wr, reg_addr, ADDR_W'(OFS_COEF1 + 4 * i))) begin
          coef_reg[i] <= reg_wdata;
        end
      end
    end
  end

  assign exc_cur_ua = exc_reg;
  assign cfg_rref = rref_reg;
  assign cfg_tref = tref_reg;

  always_comb begin
    for (int i = 0; i < NUM_COEF; i++) begin
      cfg_coef[i*32 +: 32] = coef_reg[i];
    end
  end

  // ----------------------------------------------------------------
  // Indicator codes
  // ----------------------------------------------------------------
  // Sensor error wins over the power-stage faults: with no valid
  // temperature the other reports are of little use
  always_comb begin
    err_code = LED_OFF;
    if (short_reg || open_reg) begin
      err_code = 3'h1;
    end else if (oc_lvl) begin
      err_code = 3'h2;
    end else if (ot_lvl) begin
      err_code = 3'h3;
    end
  end

  assign temp_diff = (TEMP_W+1)'(temp_meas) - (TEMP_W+1)'(temp_setpoint);

  always_comb begin
    stat_code = LED_OFF;
    if (!enabled) begin
      stat_code = LED_OFF;
    end else if (temp_diff <= $signed(TEMP_BAND) &&
                 temp_diff >= -$signed(TEMP_BAND)) begin
      stat_code = LED_STEADY;
    end else if (temp_diff < 0) begin
      stat_code = 3'h1;
    end else begin
      stat_code = 3'h2;
    end
  end

  sfl_flasher #(
    .ON_CYC(ON_CYC),
    .GAP_CYC(GAP_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_err_flash (
    .core_clk(core_clk),
    .reset(reset),
    .code(err_code),
    .led(err_led)
  );

  sfl_flasher #(
    .ON_CYC(ON_CYC),
    .GAP_CYC(GAP_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_stat_flash (
    .core_clk(core_clk),
    .reset(reset),
    .code(stat_code),
    .led(stat_led)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[EV_SHORT_BIT] = short_reg;
    status_word[EV_OPEN_BIT] = open_reg;
    status_word[EV_OVERCUR_BIT] = oc_lvl;
    status_word[EV_OVERTEMP_BIT] = ot_lvl;
    status_word[ST_ENABLED_BIT] = enabled;
    status_word[ST_ERRCODE_LSB +: 3] = err_code;
    status_word[ST_STATCODE_LSB +: 3] = stat_code;
  end

  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      OFS_CTRL: rd_mux = {31'h0000_0000, sw_en_reg};
      OFS_STATUS: rd_mux = status_word;
      OFS_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_reg};
      OFS_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_reg};
      OFS_EXC_CUR: rd_mux = {19'h0_0000, exc_reg};
      OFS_RREF: rd_mux = rref_reg;
      OFS_TREF: rd_mux = tref_reg;
      default: begin
        for (int i = 0; i < NUM_COEF; i++) begin
          if (reg_addr == ADDR_W'(OFS_COEF1 + 4 * i)) begin
            rd_mux = coef_reg[i];
          end
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: dv/sfl_checker.sv
// Port-level assertions for the sensor fault and indicator LED block
`timescale 1ns/1ps
`default_nettype none
module sfl_checker
  import sfl_pkg::*;
#(
  parameter int ON_CYC = 4,
  parameter int GAP_CYC = 3,
  parameter int PAUSE_CYC = 12
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [sfl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sfl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sfl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic [sfl_pkg::SENS_W-1:0] sens_mv,
  input wire logic sens_valid,
  input wire logic hw_enable,
  input wire logic overcur_pin,
  input wire logic overtemp_pin,
  input wire logic err_led,
  input wire logic stat_led,
  input wire logic [sfl_pkg::EXC_W-1:0] exc_cur_ua
);
  logic [31:0] wd_q;
  logic [3:0] quiet_cnt;
  int hi_cnt;
  logic quiet;

  // ----------------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------------
  // Quiet: no fault cause at the inputs
  assign quiet = sens_valid && sens_mv >= SENS_MIN_MV &&
                 sens_mv <= SENS_MAX_MV && !overcur_pin && !overtemp_pin;

  // Write data, quiet run and LED-high run
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wd_q <= '0;
      quiet_cnt <= 4'h0;
      hi_cnt <= 0;
    end else begin
      wd_q <= reg_wdata;
      quiet_cnt <= !quiet ? 4'h0 : quiet_cnt + 4'(quiet_cnt != 4'hF);
      hi_cnt <= err_led ? hi_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Read data is zero except in the cycle after a read
  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero when idle");
  exc_range_a: assert property (
    exc_cur_ua >= EXC_CUR_MIN_UA && exc_cur_ua <= EXC_CUR_MAX_UA)
    else $error("excitation current out of range");
  exc_write_a: assert property (
    (reg_wr && reg_addr == OFS_EXC_CUR) |=> exc_cur_ua ==
      (wd_q > 32'(EXC_CUR_MAX_UA) ? EXC_CUR_MAX_UA :
       wd_q < 32'(EXC_CUR_MIN_UA) ? EXC_CUR_MIN_UA : wd_q[12:0]))
    else $error("excitation write not clamped");
  exc_read_a: assert property (
    (reg_rd && reg_addr == OFS_EXC_CUR) |=>
      reg_rdata == 32'($past(exc_cur_ua)))
    else $error("excitation readback differs");
  short_flag_a: assert property (
    (sens_valid && sens_mv < SENS_MIN_MV)[*2] ##0
      (reg_rd && reg_addr == OFS_STATUS) |=>
      reg_rdata[EV_SHORT_BIT] && !reg_rdata[EV_OPEN_BIT])
    else $error("short not flagged");
  open_flag_a: assert property (
    (sens_valid && sens_mv > SENS_MAX_MV)[*2] ##0
      (reg_rd && reg_addr == OFS_STATUS) |=>
      reg_rdata[EV_OPEN_BIT] && !reg_rdata[EV_SHORT_BIT])
    else $error("open not flagged");
  // Sticky interrupt only drops on a clear or mask write
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) &&
    ($past(reg_addr) == OFS_IRQ_STAT || $past(reg_addr) == OFS_IRQ_MASK))
    else $error("interrupt dropped unasked");
  err_dark_a: assert property (quiet_cnt >= 4'hA |-> !err_led)
    else $error("error LED lit with no fault");
  stat_off_a: assert property (!hw_enable[*6] |-> !stat_led)
    else $error("status LED lit while disabled");
  err_pulse_a: assert property (err_led |-> hi_cnt < ON_CYC)
    else $error("error flash too long");

  // Main scenarios reached
  err_flash_c: cover property ($rose(err_led));
  stat_flash_c: cover property ($rose(stat_led));
  irq_raise_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: dv/sfl_partner.sv
// Behavioural RTD sensor and flash-counting LED observers
`timescale 1ns/1ps
`default_nettype none
module sfl_sensor_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [sfl_pkg::EXC_W-1:0] exc_cur_ua,
  input wire logic [15:0] r_ohm,
  output logic [sfl_pkg::SENS_W-1:0] sens_mv,
  output logic sens_valid
);
  logic [31:0] mv;

  // Ohm times microampere over a thousand gives millivolt
  assign mv = 32'(r_ohm) * 32'(exc_cur_ua) / 32'h3E8;

  // Converter clips at full scale, as a broken wire drives it there
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sens_mv <= '0;
      sens_valid <= 1'b0;
    end else begin
      sens_valid <= 1'b1;
      sens_mv <= (mv > 32'hFFF) ? 12'hFFF : mv[11:0];
    end
  end
endmodule

module sfl_flash_count #(
  parameter int PAUSE_MIN = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic led,
  output logic [3:0] count,
  output logic done
);
  logic led_q;
  logic [3:0] edge_cnt;
  int low_cnt;

  // A dark run longer than any gap closes one group of flashes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      led_q <= 1'b0;
      edge_cnt <= 4'h0;
      low_cnt <= 0;
      count <= 4'h0;
      done <= 1'b0;
    end else begin
      led_q <= led;
      done <= 1'b0;
      low_cnt <= led ? 0 : low_cnt + 1;
      if (led && !led_q) begin
        edge_cnt <= edge_cnt + 4'h1;
      end else if (low_cnt == PAUSE_MIN && edge_cnt != 4'h0) begin
        count <= edge_cnt;
        done <= 1'b1;
        edge_cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/sfl_top_tb.sv
// Self-checking bench for the sensor fault and indicator LED block
`timescale 1ns/1ps
`default_nettype none
module sfl_top_tb;
  import sfl_pkg::*;
  // Short flash timing keeps the run brief
  localparam logic [31:0] XW [5] = '{32'h1388, 32'h0FA0, 32'h0FA1,
                                     32'h0063, 32'h0064};
  localparam logic [15:0] RV [5] = '{16'h004F, 16'h0050, 16'h08FC,
                                     16'h08FD, 16'h03E8};
  localparam int RS [5] = '{1, 0, 0, 2, 0};
  localparam int DT [7] = '{0, 100, -100, -101, 101, -3000, 3000};
  localparam int DS [7] = '{4, 4, 4, 1, 2, 1, 2};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq, sens_valid, err_led, stat_led, err_done, stat_done;
  logic [SENS_W-1:0] sens_mv;
  logic signed [TEMP_W-1:0] temp_meas = '0;
  logic signed [TEMP_W-1:0] temp_setpoint = '0;
  logic signed [TEMP_W-1:0] sp;
  logic hw_enable = 1'b0;
  logic overcur_pin = 1'b0;
  logic overtemp_pin = 1'b0;
  logic [EXC_W-1:0] exc_cur_ua;
  logic [31:0] cfg_rref, cfg_tref, v;
  logic [NUM_COEF*32-1:0] cfg_coef;
  logic [15:0] r_ohm = 16'h03E8;
  logic [3:0] err_cnt, stat_cnt;
  logic rd_seen = 1'b0;
  logic [31:0] coef [NUM_COEF];
  logic [31:0] exp_rd [$];
  logic [3:0] exp_err [$];
  logic [3:0] exp_stat [$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Design, partner and tasks
  // ----------------------------------------------------------------
  always #4 core_clk = ~core_clk;

  sfl_top #(.ON_CYC(4), .GAP_CYC(3), .PAUSE_CYC(12)) u_dut (.core_clk,
    .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .sens_mv, .sens_valid, .temp_meas, .temp_setpoint, .hw_enable,
    .overcur_pin, .overtemp_pin, .err_led, .stat_led, .exc_cur_ua,
    .cfg_rref, .cfg_tref, .cfg_coef);
  sfl_sensor_model u_sensor (.core_clk, .reset, .exc_cur_ua, .r_ohm,
    .sens_mv, .sens_valid);
  sfl_flash_count u_err_obs (.core_clk, .reset, .led(err_led),
    .count(err_cnt), .done(err_done));
  sfl_flash_count u_stat_obs (.core_clk, .reset, .led(stat_led),
    .count(stat_cnt), .done(stat_done));

  task automatic chk(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // Skip a cut group, expect two whole ones
  task automatic flashes(input logic [3:0] ne, ns);
    repeat (80) @(posedge core_clk);
    repeat (2) begin
      if (ne != 4'h0) exp_err.push_back(ne);
      if (ns != 4'h0) exp_stat.push_back(ns);
    end
    while (exp_err.size() + exp_stat.size() != 0) @(posedge core_clk);
  endtask

  // Watcher pops the oldest note per result
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 6000) begin
      err_count++;
      end_of_test();
    end
    if (rd_seen) chk("reg_rdata", reg_rdata, exp_rd.pop_front());
    rd_seen <= reg_rd;
    if (err_done && exp_err.size() != 0)
      chk("err_flashes", 32'(err_cnt), 32'(exp_err.pop_front()));
    if (stat_done && exp_stat.size() != 0)
      chk("stat_flashes", 32'(stat_cnt), 32'(exp_stat.pop_front()));
  end

  initial begin
    void'($urandom(72784));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    chk("exc_cur_ua", 32'(exc_cur_ua), 32'h3E8);
    rd(OFS_EXC_CUR, 32'h3E8);
    rd(OFS_RREF, RREF_RST_MOHM);
    rd(OFS_TREF, TREF_RST);
    rd(OFS_COEF1, COEF1_RST);
    rd(OFS_COEF1 + 8'h04, COEF2_RST);
    for (int k = 2; k < NUM_COEF; k++) rd(OFS_COEF1 + 8'(4 * k), '0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_CTRL, 32'h1);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = (i < 5) ? XW[i] : 32'($urandom_range(6000));
      wr(OFS_EXC_CUR, v);
      rd(OFS_EXC_CUR, v > 32'hFA0 ? 32'hFA0 : v < 32'h64 ? 32'h64 : v);
    end
    wr(OFS_EXC_CUR, 32'h3E8);
    v = $urandom;
    wr(OFS_RREF, v);
    rd(OFS_RREF, v);
    chk("cfg_rref", cfg_rref, v);
    v = -32'($urandom_range(1, 32'hFFF));
    wr(OFS_TREF, v);
    rd(OFS_TREF, v);
    chk("cfg_tref", cfg_tref, v);
    for (int k = 0; k < NUM_COEF; k++) begin
      coef[k] = $urandom_range(1, 32'h0FFF_FFFF);
      wr(OFS_COEF1 + 8'(4 * k), coef[k]);
      rd(OFS_COEF1 + 8'(4 * k), coef[k]);
      chk("cfg_coef", cfg_coef[k*32 +: 32], coef[k]);
    end
    // each limit and one mV beyond it
    for (int i = 0; i < 5; i++) begin
      r_ohm <= RV[i];
      repeat (4) @(posedge core_clk);
      rd(OFS_STATUS, 32'(RS[i]) | (RS[i] != 0 ? 32'h100 : 32'h0));
    end
    // Sticky event, masked, unmasked, cleared
    wr(OFS_IRQ_STAT, 32'hF);
    r_ohm <= 16'h004F;
    repeat (4) @(posedge core_clk);
    #1 chk("irq", 32'(irq), 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge core_clk);
    #1 chk("irq", 32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    @(posedge core_clk);
    #1 chk("irq", 32'(irq), 32'h0);
    flashes(4'h1, 4'h0);
    r_ohm <= 16'h03E8;
    overcur_pin <= 1'b1;
    flashes(4'h2, 4'h0);
    overcur_pin <= 1'b0;
    overtemp_pin <= 1'b1;
    flashes(4'h3, 4'h0);
    overtemp_pin <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1 chk("err_led", 32'(err_led), 32'h0);
    chk("stat_led", 32'(stat_led), 32'h0);
    hw_enable <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      sp = 16'($urandom_range(8000)) - 16'sh0FA0;
      temp_setpoint <= sp;
      temp_meas <= sp + 16'(DT[i]);
      if (DS[i] == 4) begin
        repeat (10) @(posedge core_clk);
        #1 chk("stat_led", 32'(stat_led), 32'h1);
      end else begin
        flashes(4'h0, 4'(DS[i]));
      end
    end
    wr(OFS_CTRL, 32'h0);
    repeat (8) @(posedge core_clk);
    #1 chk("stat_led", 32'(stat_led), 32'h0);
    hw_enable <= 1'b0;
    repeat (10) @(posedge core_clk);
    end_of_test();
  end
endmodule

bind sfl_top sfl_checker #(.ON_CYC(ON_CYC), .GAP_CYC(GAP_CYC),
  .PAUSE_CYC(PAUSE_CYC)) u_chk (.core_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq, .sens_mv, .sens_valid, .hw_enable,
  .overcur_pin, .overtemp_pin, .err_led, .stat_led, .exc_cur_ua);
`default_nettype wire
